// >>> otg_mode_pkg.sv
package otg_mode_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GLOBAL_MODE_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_REVERSE_MODE_CONTROL = 8'h0e;
  localparam logic [7:0] ADDR_REVERSE_MODE_CONFIG = 8'h0f;
  localparam logic [7:0] ADDR_REVERSE_RAMP_AND_LIMIT = 8'h10;
  localparam logic [7:0] ADDR_REVERSE_VOLTAGE_CODE_A = 8'h13;
  localparam logic [7:0] ADDR_REVERSE_VOLTAGE_CODE_B = 8'h14;
  localparam logic [7:0] ADDR_OUTPUT_CURRENT_SCALE = 8'h15;
  localparam logic [7:0] ADDR_BATTERY_LOW_THRESHOLD = 8'h1a;
  localparam logic [7:0] ADDR_REVERSE_MODE_STATUS = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_HIGH_IMPEDANCE_FORCE = 0;
  localparam int BIT_TRANSPORT_LOW_POWER = 1;
  localparam int BIT_CHARGE_REQUEST = 2;
  localparam int BIT_PIN_PATH_ENABLE = 0;
  localparam int BIT_REGISTER_PATH_ENABLE = 1;
  localparam int BIT_PIN_OVERRIDE = 2;
  localparam int POS_SOFTSTART_TIME_SELECT = 3;
  localparam int POS_START_DELAY_SELECT = 5;
  localparam int POS_BATTERY_CUTOFF_OFFSET = 0;
  localparam int BIT_DISCHARGE_SINK_ENABLE = 3;
  localparam int POS_REVERSE_RAMP_RATE = 0;
  localparam int POS_BATTERY_LIMIT_SCALE = 2;
  localparam int BIT_OUTPUT_LIMIT_FLAG = 3;
  localparam int BIT_BATTERY_LIMIT_FLAG = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_GLOBAL_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_REVERSE_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_REVERSE_MODE_CONFIG = 8'h00;
  localparam logic [7:0] RST_REVERSE_RAMP_AND_LIMIT = 8'h04;
  localparam logic [9:0] RST_REVERSE_VOLTAGE_CODE = 10'h06e;
  localparam logic [6:0] RST_OUTPUT_CURRENT_SCALE = 7'h64;
  localparam logic [6:0] RST_BATTERY_LOW_THRESHOLD = 7'h00;

  // ----------------------------------------------------------------
  // Analog scaling and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] VOUT_BASE_MV = 16'd2960;
  localparam logic [15:0] VOUT_STEP_MV = 16'd20;
  localparam logic [15:0] VOUT_FAULT_MV = 16'd3000;
  localparam logic [7:0] OV_PERCENT = 8'd108;
  localparam logic [7:0] FULL_PERCENT = 8'd100;
  localparam logic [6:0] SCALE_MIN_CODE = 7'h01;
  localparam logic [6:0] SCALE_MAX_CODE = 7'h64;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS = 1000000 / TICK_NS;
  localparam int START_DELAY_MS [4] = '{0, 10, 100, 1000};
  localparam int SOFTSTART_MS [4] = '{1, 2, 4, 8};
  localparam int HICCUP_OFF_MS = 3000;
  localparam int OV_PERSIST_MS = 100;
  // Ramp of one 20 mV step: 1, 0.5, 0.2 and 0.1 V/ms.
  localparam int RAMP_STEP_US [4] = '{20, 40, 100, 200};
  localparam int TICKS_PER_US = 1000 / TICK_NS + ((1000 % TICK_NS) != 0 ? 1 : 0);
  localparam logic [8:0] BAT_LIMIT_PERCENT [4] = '{9'd0, 9'd150, 9'd200, 9'd300};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_HIZ,
    MODE_CHARGE,
    MODE_REVERSE,
    MODE_TRANSPORT_LOW_POWER_MODE
  } mode_type;

  typedef enum logic [2:0] {
    REV_RESET,
    REV_DELAY,
    REV_SOFTSTART,
    REV_REGULATE,
    REV_RETRY
  } rev_state_type;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [15:0] vout_mv;
    logic [7:0]  vbat_code;
    logic [7:0]  iout_percent;
    logic [8:0]  ibat_percent;
  } sense_type;

  typedef struct packed {
    logic        converter_on;
    logic        sink_on;
    logic        output_cc;
    logic        input_cc;
    logic [15:0] target_mv;
  } drive_type;

endpackage

// >>> otg_mode_control.sv
`timescale 1ns/1ns
`default_nettype none
module otg_mode_control
  import otg_mode_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire reg_req_type reg_req_i,
  output logic [7:0]       reg_rdata_o,
  input  wire logic        reverse_request_pin_n_i,
  input  wire sense_type   sense_i,
  output drive_type        drive_o,
  output logic             reverse_mode_o,
  output logic             charge_mode_o,
  output logic             transport_low_power_mode_mode_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mode_type      mode;
    rev_state_type rstate;
    logic [7:0]    global_mode_control_reg;
    logic [7:0]    reverse_mode_control_reg;
    logic [7:0]    reverse_mode_config_reg;
    logic [7:0]    reverse_ramp_and_limit_reg;
    logic [7:0]    code_low_reg;
    logic [9:0]    reverse_voltage_code_reg;
    logic [6:0]    output_current_scale_reg;
    logic [6:0]    battery_low_threshold_reg;
    logic [15:0]   prescale_reg;
    logic [21:0]   timer_reg;
    logic [21:0]   ov_timer_reg;
    logic [15:0]   ramp_mv_reg;
    logic [7:0]    ramp_timer_reg;
    logic          sink_reg;
    logic          output_cc_reg;
    logic          input_cc_reg;
    logic [7:0]    rdata_reg;
  } state_type;

  state_type cur_reg;
  state_type cur_next;

  logic        tick;
  logic        force_hiz;
  logic        transport_low_power_mode_cmd;
  logic        charge_req;
  logic        pin_path;
  logic        reg_path;
  logic        reverse_req;
  logic        reverse_keep;
  logic [15:0] final_mv;
  logic [23:0] vout_scaled;
  logic [23:0] ov_limit;
  logic        over_voltage;
  logic        output_fault;
  logic [7:0]  cutoff;
  logic        battery_low;
  logic [6:0]  scale_eff;
  logic [1:0]  ss_sel;
  logic [1:0]  dly_sel;
  logic [1:0]  rate_sel;
  logic [1:0]  blim_sel;
  logic [2:0]  state_code;
  logic [7:0]  status_byte;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  assign force_hiz  = cur_reg.global_mode_control_reg[BIT_HIGH_IMPEDANCE_FORCE];
  assign transport_low_power_mode_cmd   = cur_reg.global_mode_control_reg[BIT_TRANSPORT_LOW_POWER];
  assign charge_req = cur_reg.global_mode_control_reg[BIT_CHARGE_REQUEST];
  assign ss_sel     = cur_reg.reverse_mode_control_reg[POS_SOFTSTART_TIME_SELECT +: 2];
  assign dly_sel    = cur_reg.reverse_mode_control_reg[POS_START_DELAY_SELECT +: 2];
  assign rate_sel   = cur_reg.reverse_ramp_and_limit_reg[POS_REVERSE_RAMP_RATE +: 2];
  assign blim_sel   = cur_reg.reverse_ramp_and_limit_reg[POS_BATTERY_LIMIT_SCALE +: 2];

  // The register enable bit gates the pin path too in reverse_keep, though not in pin_path entry,
  // since clearing it must end the mode whichever path started it.
  assign pin_path = cur_reg.reverse_mode_control_reg[BIT_PIN_PATH_ENABLE]
                  && !cur_reg.reverse_mode_control_reg[BIT_PIN_OVERRIDE]
                  && !reverse_request_pin_n_i;
  assign reg_path = cur_reg.reverse_mode_control_reg[BIT_REGISTER_PATH_ENABLE]
                  && cur_reg.reverse_mode_control_reg[BIT_PIN_OVERRIDE];
  assign reverse_req = (pin_path || reg_path) && !force_hiz
                     && (blim_sel != 2'b00);
  assign reverse_keep = !force_hiz
                      && cur_reg.reverse_mode_control_reg[BIT_REGISTER_PATH_ENABLE]
                      && (cur_reg.reverse_mode_control_reg[BIT_PIN_OVERRIDE]
                          || !reverse_request_pin_n_i)
                      && (blim_sel != 2'b00);

  // ----------------------------------------------------------------
  // Analog comparisons
  // ----------------------------------------------------------------
  assign final_mv = VOUT_BASE_MV + 16'(cur_reg.reverse_voltage_code_reg * VOUT_STEP_MV);
  assign vout_scaled = 24'(sense_i.vout_mv * FULL_PERCENT);
  assign ov_limit = 24'(cur_reg.ramp_mv_reg * OV_PERCENT);
  assign over_voltage = vout_scaled > ov_limit;
  assign output_fault = sense_i.vout_mv < VOUT_FAULT_MV;
  assign cutoff = {1'b0, cur_reg.battery_low_threshold_reg}
                - {5'b0, cur_reg.reverse_mode_config_reg[POS_BATTERY_CUTOFF_OFFSET +: 3]};
  assign battery_low = sense_i.vbat_code < cutoff;

  always_comb begin
    if (cur_reg.output_current_scale_reg < SCALE_MIN_CODE) begin
      scale_eff = SCALE_MIN_CODE;
    end else if (cur_reg.output_current_scale_reg > SCALE_MAX_CODE) begin
      scale_eff = SCALE_MAX_CODE;
    end else begin
      scale_eff = cur_reg.output_current_scale_reg;
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_comb begin
    case (cur_reg.rstate)
      REV_SOFTSTART: state_code = 3'h1;
      REV_REGULATE:  state_code = 3'h2;
      REV_RETRY:     state_code = 3'h3;
      default:       state_code = 3'h0;
    endcase
    if (cur_reg.mode != MODE_REVERSE) begin
      state_code = 3'h0;
    end
    status_byte = 8'h00;
    status_byte[2:0] = state_code;
    status_byte[BIT_OUTPUT_LIMIT_FLAG] = cur_reg.output_cc_reg;
    status_byte[BIT_BATTERY_LIMIT_FLAG] = cur_reg.input_cc_reg;
  end

  assign tick = cur_reg.prescale_reg == 16'(TICK_DIV - 1);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    cur_next = cur_reg;
    cur_next.prescale_reg = tick ? 16'h0000 : cur_reg.prescale_reg + 16'h0001;

    // Register writes. The code takes effect only on the high byte, so the
    // low byte alone never moves the target.
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        ADDR_GLOBAL_MODE_CONTROL:    cur_next.global_mode_control_reg = reg_req_i.wdata;
        ADDR_REVERSE_MODE_CONTROL:   cur_next.reverse_mode_control_reg = reg_req_i.wdata;
        ADDR_REVERSE_MODE_CONFIG:    cur_next.reverse_mode_config_reg = reg_req_i.wdata;
        ADDR_REVERSE_RAMP_AND_LIMIT: cur_next.reverse_ramp_and_limit_reg = reg_req_i.wdata;
        ADDR_REVERSE_VOLTAGE_CODE_A: cur_next.code_low_reg = reg_req_i.wdata;
        ADDR_REVERSE_VOLTAGE_CODE_B: begin
          cur_next.reverse_voltage_code_reg = {reg_req_i.wdata[1:0], cur_reg.code_low_reg};
        end
        ADDR_OUTPUT_CURRENT_SCALE:   cur_next.output_current_scale_reg = reg_req_i.wdata[6:0];
        ADDR_BATTERY_LOW_THRESHOLD:  cur_next.battery_low_threshold_reg = reg_req_i.wdata[6:0];
        default: begin
        end
      endcase
    end

    case (reg_req_i.addr)
      ADDR_GLOBAL_MODE_CONTROL:    cur_next.rdata_reg = cur_reg.global_mode_control_reg;
      ADDR_REVERSE_MODE_CONTROL:   cur_next.rdata_reg = cur_reg.reverse_mode_control_reg;
      ADDR_REVERSE_MODE_CONFIG:    cur_next.rdata_reg = cur_reg.reverse_mode_config_reg;
      ADDR_REVERSE_RAMP_AND_LIMIT: cur_next.rdata_reg = cur_reg.reverse_ramp_and_limit_reg;
      ADDR_REVERSE_VOLTAGE_CODE_A: cur_next.rdata_reg = cur_reg.reverse_voltage_code_reg[7:0];
      ADDR_REVERSE_VOLTAGE_CODE_B: cur_next.rdata_reg = {6'b0, cur_reg.reverse_voltage_code_reg[9:8]};
      ADDR_OUTPUT_CURRENT_SCALE:   cur_next.rdata_reg = {1'b0, cur_reg.output_current_scale_reg};
      ADDR_BATTERY_LOW_THRESHOLD:  cur_next.rdata_reg = {1'b0, cur_reg.battery_low_threshold_reg};
      ADDR_REVERSE_MODE_STATUS:    cur_next.rdata_reg = status_byte;
      default:                     cur_next.rdata_reg = 8'h00;
    endcase

    // Top-level mode.
    case (cur_reg.mode)
      MODE_HIZ: begin
        if (transport_low_power_mode_cmd) begin
          cur_next.mode = MODE_TRANSPORT_LOW_POWER_MODE;
        end else if (reverse_req) begin
          cur_next.mode = MODE_REVERSE;
          cur_next.rstate = REV_RESET;
        end else if (charge_req && !force_hiz) begin
          cur_next.mode = MODE_CHARGE;
        end
      end
      MODE_CHARGE: begin
        if (transport_low_power_mode_cmd || force_hiz || !charge_req) begin
          cur_next.mode = MODE_HIZ;
        end
      end
      MODE_REVERSE: begin
        if (transport_low_power_mode_cmd) begin
          cur_next.mode = MODE_TRANSPORT_LOW_POWER_MODE;
        end else if (!reverse_keep) begin
          cur_next.mode = MODE_HIZ;
        end
      end
      MODE_TRANSPORT_LOW_POWER_MODE: begin
        if (!transport_low_power_mode_cmd) begin
          cur_next.mode = MODE_HIZ;
        end
      end
      default: cur_next.mode = MODE_HIZ;
    endcase

    // Reverse-mode sequencer.
    if (cur_reg.mode != MODE_REVERSE) begin
      cur_next.rstate = REV_RESET;
      cur_next.timer_reg = 22'h0;
      cur_next.ov_timer_reg = 22'h0;
      cur_next.sink_reg = 1'b0;
      cur_next.output_cc_reg = 1'b0;
      cur_next.input_cc_reg = 1'b0;
      cur_next.ramp_mv_reg = final_mv;
    end else begin
      if (tick) begin
        cur_next.timer_reg = cur_reg.timer_reg + 22'h1;
      end
      case (cur_reg.rstate)
        REV_RESET: begin
          cur_next.timer_reg = 22'h0;
          cur_next.ov_timer_reg = 22'h0;
          cur_next.sink_reg = 1'b0;
          cur_next.output_cc_reg = 1'b0;
          cur_next.input_cc_reg = 1'b0;
          cur_next.ramp_mv_reg = final_mv;
          if (!battery_low) begin
            cur_next.rstate = REV_DELAY;
          end
        end
        REV_DELAY: begin
          if (cur_reg.timer_reg >= 22'(START_DELAY_MS[dly_sel] * TICKS_PER_MS)) begin
            cur_next.rstate = REV_SOFTSTART;
            cur_next.timer_reg = 22'h0;
          end
        end
        REV_SOFTSTART: begin
          cur_next.ramp_mv_reg = final_mv;
          if (cur_reg.timer_reg >= 22'(SOFTSTART_MS[ss_sel] * TICKS_PER_MS)) begin
            cur_next.rstate = REV_REGULATE;
            cur_next.timer_reg = 22'h0;
          end
        end
        REV_REGULATE: begin
          cur_next.timer_reg = 22'h0;
          cur_next.output_cc_reg = sense_i.iout_percent > {1'b0, scale_eff};
          cur_next.input_cc_reg = sense_i.ibat_percent > BAT_LIMIT_PERCENT[blim_sel];
          if (output_fault) begin
            cur_next.rstate = REV_RETRY;
            cur_next.output_cc_reg = 1'b0;
            cur_next.input_cc_reg = 1'b0;
            cur_next.sink_reg = 1'b0;
          end
        end
        REV_RETRY: begin
          if (cur_reg.timer_reg >= 22'(HICCUP_OFF_MS * TICKS_PER_MS)) begin
            cur_next.rstate = REV_RESET;
          end
        end
        default: cur_next.rstate = REV_RESET;
      endcase

      // Target ramp, one 20 mV step per interval.
      if (cur_reg.rstate == REV_REGULATE) begin
        if (cur_reg.ramp_mv_reg == final_mv) begin
          cur_next.ramp_timer_reg = 8'h00;
          if (sense_i.vout_mv <= final_mv) begin
            cur_next.sink_reg = 1'b0;
          end
        end else begin
          if (final_mv < cur_reg.ramp_mv_reg
              && cur_reg.reverse_mode_config_reg[BIT_DISCHARGE_SINK_ENABLE]) begin
            cur_next.sink_reg = 1'b1;
          end
          if (tick) begin
            cur_next.ramp_timer_reg = cur_reg.ramp_timer_reg + 8'h01;
          end
          if (cur_reg.ramp_timer_reg >= 8'(RAMP_STEP_US[rate_sel] * TICKS_PER_US)) begin
            cur_next.ramp_timer_reg = 8'h00;
            cur_next.ramp_mv_reg = final_mv > cur_reg.ramp_mv_reg
                                 ? cur_reg.ramp_mv_reg + VOUT_STEP_MV
                                 : cur_reg.ramp_mv_reg - VOUT_STEP_MV;
          end
        end
      end

      // Overvoltage persistence runs in any running state.
      if (over_voltage && cur_reg.rstate != REV_RESET) begin
        if (tick) begin
          cur_next.ov_timer_reg = cur_reg.ov_timer_reg + 22'h1;
        end
        if (cur_reg.ov_timer_reg >= 22'(OV_PERSIST_MS * TICKS_PER_MS)) begin
          cur_next.mode = MODE_HIZ;
        end
      end else begin
        cur_next.ov_timer_reg = 22'h0;
      end

      // Battery cutoff wins over every other step.
      if (battery_low) begin
        cur_next.rstate = REV_RESET;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_reg <= '0;
      cur_reg.mode <= MODE_HIZ;
      cur_reg.rstate <= REV_RESET;
      cur_reg.global_mode_control_reg <= RST_GLOBAL_MODE_CONTROL;
      cur_reg.reverse_mode_control_reg <= RST_REVERSE_MODE_CONTROL;
      cur_reg.reverse_mode_config_reg <= RST_REVERSE_MODE_CONFIG;
      cur_reg.reverse_ramp_and_limit_reg <= RST_REVERSE_RAMP_AND_LIMIT;
      cur_reg.code_low_reg <= RST_REVERSE_VOLTAGE_CODE[7:0];
      cur_reg.reverse_voltage_code_reg <= RST_REVERSE_VOLTAGE_CODE;
      cur_reg.output_current_scale_reg <= RST_OUTPUT_CURRENT_SCALE;
      cur_reg.battery_low_threshold_reg <= RST_BATTERY_LOW_THRESHOLD;
    end else if (ce_i) begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Switching is cut in the same cycle an overvoltage is seen.
  assign drive_o.converter_on = cur_reg.mode == MODE_REVERSE
                              && (cur_reg.rstate == REV_SOFTSTART
                                  || cur_reg.rstate == REV_REGULATE)
                              && !over_voltage;
  assign drive_o.sink_on = cur_reg.sink_reg;
  assign drive_o.output_cc = cur_reg.output_cc_reg;
  assign drive_o.input_cc = cur_reg.input_cc_reg;
  assign drive_o.target_mv = cur_reg.ramp_mv_reg;
  assign reg_rdata_o = cur_reg.rdata_reg;
  assign reverse_mode_o = cur_reg.mode == MODE_REVERSE;
  assign charge_mode_o = cur_reg.mode == MODE_CHARGE;
  assign transport_low_power_mode_mode_o = cur_reg.mode == MODE_TRANSPORT_LOW_POWER_MODE;

endmodule
`default_nettype wire

// >>> otg_mode_control_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module otg_mode_checker
  import otg_mode_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        ce_i,
  input wire reg_req_type reg_req_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        reverse_request_pin_n_i,
  input wire sense_type   sense_i,
  input wire drive_type   drive_o,
  input wire logic        reverse_mode_o,
  input wire logic        charge_mode_o,
  input wire logic        transport_low_power_mode_mode_o
);
  // Widened so that 108 percent of a full-scale target cannot wrap.
  logic over_v;
  assign over_v = 32'(sense_i.vout_mv) * 100 > 32'(drive_o.target_mv) * 108;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  mode_excl_a: assert property (reverse_mode_o |-> !charge_mode_o && !transport_low_power_mode_mode_o)
    else $error("reverse mode overlaps another mode");
  entry_idle_a: assert property ($rose(reverse_mode_o) |-> !$past(charge_mode_o) && !$past(transport_low_power_mode_mode_o))
    else $error("reverse entered from a busy mode");
  exit_idle_a: assert property ($fell(reverse_mode_o) |-> !charge_mode_o)
    else $error("reverse left to charge mode");
  conv_mode_a: assert property (drive_o.converter_on |-> reverse_mode_o || $past(reverse_mode_o))
    else $error("converter on outside reverse mode");
  force_hiz_a: assert property ((ce_i && reg_req_i.wr && reg_req_i.addr == ADDR_GLOBAL_MODE_CONTROL
    && reg_req_i.wdata[BIT_HIGH_IMPEDANCE_FORCE]) ##1 ce_i |-> ##2 !reverse_mode_o && !charge_mode_o)
    else $error("mode active after force bit");
  ov_cut_a: assert property (over_v |-> !drive_o.converter_on)
    else $error("switching during overvoltage");
  out_cc_a: assert property ($rose(drive_o.output_cc) |-> $past(sense_i.iout_percent) != 8'h00)
    else $error("output limit below one percent");
  bat_cc_a: assert property ($rose(drive_o.input_cc) |-> $past(sense_i.ibat_percent) > 9'd150)
    else $error("battery limit below 150 percent");
  idle_flags_a: assert property (!reverse_mode_o ##1 !reverse_mode_o
    |-> !drive_o.output_cc && !drive_o.input_cc && !drive_o.sink_on)
    else $error("limit flag outside reverse mode");
endmodule
bind otg_mode_control otg_mode_checker #(.TICK_DIV(TICK_DIV)) otg_mode_checker_inst (
  .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .reverse_request_pin_n_i(reverse_request_pin_n_i),
  .sense_i(sense_i), .drive_o(drive_o), .reverse_mode_o(reverse_mode_o),
  .charge_mode_o(charge_mode_o), .transport_low_power_mode_mode_o(transport_low_power_mode_mode_o));
`default_nettype wire

// >>> otg_load_model.sv
`timescale 1ns/1ns
`default_nettype none
module otg_load_model
  import otg_mode_pkg::*;
(
  input  wire logic       clk_i,
  input  wire drive_type  drive_i,
  input  wire logic       short_i,
  input  wire logic       supply_i,
  input  wire logic [7:0] iout_i,
  input  wire logic [8:0] ibat_i,
  output var sense_type   sense_o
);
  // The node lags the target by a clock; a foreign supply holds it high even with switching off.
  always_ff @(posedge clk_i) begin
    sense_o.vbat_code <= 8'h80;
    sense_o.iout_percent <= iout_i;
    sense_o.ibat_percent <= ibat_i;
    if (short_i) begin
      sense_o.vout_mv <= 16'd1000;
    end else if (supply_i) begin
      sense_o.vout_mv <= 16'((32'(drive_i.target_mv) * 110) / 100);
    end else begin
      sense_o.vout_mv <= drive_i.target_mv;
    end
  end
endmodule
`default_nettype wire

// >>> test_otg_mode_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_otg_mode_control
  import otg_mode_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  reg_req_type reg_req_i = '0;
  logic        pin_n = 1'b1;
  logic        short_v = 1'b0;
  logic        supply_v = 1'b0;
  logic [7:0]  iout = 8'h00;
  logic [8:0]  ibat = 9'h000;
  logic [7:0]  reg_rdata_o;
  sense_type   sense_i;
  drive_type   drive_o;
  logic        reverse_mode_o;
  logic        charge_mode_o;
  logic        transport_low_power_mode_mode_o;
  logic        chk = 1'b0;
  logic        chk_d = 1'b0;
  logic        ce = 1'b1;
  logic [17:0] notes[$];
  logic [17:0] note;
  logic [15:0] seen;
  logic [15:0] rst_tab [6] = '{16'h1004, 16'h1564, 16'h0e00, 16'h0000, 16'h2000, 16'h0100};
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          seed = 32'h4e04;
  initial forever #5 clk_i = ~clk_i;
  otg_mode_control #(.TICK_DIV(1)) otg_mode_control_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .ce_i(ce), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .reverse_request_pin_n_i(pin_n), .sense_i(sense_i), .drive_o(drive_o),
    .reverse_mode_o(reverse_mode_o), .charge_mode_o(charge_mode_o), .transport_low_power_mode_mode_o(transport_low_power_mode_mode_o));
  otg_load_model otg_load_model_inst (.clk_i(clk_i), .drive_i(drive_o), .short_i(short_v),
    .supply_i(supply_v), .iout_i(iout), .ibat_i(ibat), .sense_o(sense_i));
  // Notes carry a selector in bits 17:16: zero picks read data, one the mode levels with
  // the sink, two the ramped target.
  always @(posedge clk_i) chk_d <= chk;
  always @(negedge clk_i) begin
    if (chk_d) begin
      note = notes.pop_front();
      case (note[17:16])
        2'd0: seen = {8'h00, reg_rdata_o};
        2'd1: seen = {11'h000, drive_o.sink_on, reverse_mode_o, charge_mode_o, transport_low_power_mode_mode_o,
                      drive_o.converter_on};
        default: seen = drive_o.target_mv;
      endcase
      n_compared++;
      if (seen !== note[15:0]) begin
        failures++;
        $display("Error at %0t: got %h expected %h", $time, seen, note[15:0]);
      end
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_req_i = '{1'b1, a, d};
    @(negedge clk_i);
    reg_req_i.wr = 1'b0;
  endtask
  task automatic exp(input logic [1:0] sel, input logic [7:0] a, input logic [15:0] e);
    @(negedge clk_i);
    reg_req_i.addr = a;
    notes.push_back({sel, e});
    chk = 1'b1;
    @(negedge clk_i);
    chk = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // The ceiling sits well above the roughly 1500 cycles the sequence needs.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    idle(12);
    resetn_i = 1'b1;
    foreach (rst_tab[i]) exp(0, rst_tab[i][15:8], rst_tab[i][7:0]);
    $display("reset values test done");
    wr(ADDR_GLOBAL_MODE_CONTROL, 8'h01);
    wr(ADDR_REVERSE_MODE_CONTROL, 8'h06);
    idle(4);
    exp(1, 8'h00, 8'h00);
    wr(ADDR_GLOBAL_MODE_CONTROL, 8'h04);
    idle(8);
    exp(1, 8'h00, 8'h09);
    exp(0, ADDR_REVERSE_MODE_STATUS, 8'h01);
    idle(900);
    exp(0, ADDR_REVERSE_MODE_STATUS, 8'h01);
    idle(110);
    exp(0, ADDR_REVERSE_MODE_STATUS, 8'h02);
    $display("start sequence test done");
    wr(ADDR_OUTPUT_CURRENT_SCALE, 8'h00);
    iout = 8'd2;
    idle(3);
    exp(0, ADDR_REVERSE_MODE_STATUS, 8'h0a);
    wr(ADDR_OUTPUT_CURRENT_SCALE, 8'h7f);
    exp(0, ADDR_OUTPUT_CURRENT_SCALE, 8'h7f);
    iout = 8'd101;
    idle(3);
    exp(0, ADDR_REVERSE_MODE_STATUS, 8'h0a);
    repeat (4) begin
      iout = 8'($unsigned($random(seed)) % 100);
      idle(3);
      exp(0, ADDR_REVERSE_MODE_STATUS, 8'h02);
    end
    iout = 8'd0;
    for (int k = 1; k < 4; k++) begin
      wr(ADDR_REVERSE_RAMP_AND_LIMIT, 8'(k << 2));
      ibat = BAT_LIMIT_PERCENT[k] + 9'd1;
      idle(3);
      exp(0, ADDR_REVERSE_MODE_STATUS, 8'h12);
      ibat = BAT_LIMIT_PERCENT[k] - 9'd1;
      idle(3);
      exp(0, ADDR_REVERSE_MODE_STATUS, 8'h02);
    end
    $display("current limit test done");
    wr(ADDR_REVERSE_MODE_CONFIG, 8'h08);
    wr(ADDR_REVERSE_VOLTAGE_CODE_A, 8'h73);
    idle(30);
    exp(2, 8'h00, 16'd5160);
    wr(ADDR_REVERSE_VOLTAGE_CODE_B, 8'h00);
    idle(47);
    exp(2, 8'h00, 16'd5200);
    idle(60);
    exp(2, 8'h00, 16'd5260);
    wr(ADDR_REVERSE_VOLTAGE_CODE_A, 8'h6e);
    wr(ADDR_REVERSE_VOLTAGE_CODE_B, 8'h00);
    idle(47);
    exp(1, 8'h00, 8'h19);
    idle(60);
    exp(1, 8'h00, 8'h09);
    exp(2, 8'h00, 16'd5160);
    $display("voltage ramp test done");
    supply_v = 1'b1;
    idle(2);
    exp(1, 8'h00, 8'h08);
    supply_v = 1'b0;
    short_v = 1'b1;
    idle(4);
    exp(0, ADDR_REVERSE_MODE_STATUS, 8'h03);
    exp(1, 8'h00, 8'h08);
    short_v = 1'b0;
    wr(ADDR_REVERSE_MODE_CONTROL, 8'h00);
    idle(4);
    // The charge request is still set, so idle hands over to charge mode at once.
    exp(1, 8'h00, 8'h04);
    exp(0, ADDR_REVERSE_MODE_STATUS, 8'h00);
    $display("fault test done");
    wr(ADDR_REVERSE_MODE_CONTROL, 8'h23);
    pin_n = 1'b0;
    idle(4);
    exp(1, 8'h00, 8'h04);
    wr(ADDR_GLOBAL_MODE_CONTROL, 8'h00);
    idle(4);
    exp(1, 8'h00, 8'h08);
    pin_n = 1'b1;
    idle(4);
    exp(1, 8'h00, 8'h00);
    wr(ADDR_REVERSE_MODE_CONTROL, 8'h27);
    idle(4);
    exp(1, 8'h00, 8'h08);
    wr(ADDR_GLOBAL_MODE_CONTROL, 8'h02);
    idle(4);
    exp(1, 8'h00, 8'h02);
    ce = 1'b0;
    wr(ADDR_GLOBAL_MODE_CONTROL, 8'h00);
    exp(1, 8'h00, 8'h02);
    ce = 1'b1;
    $display("entry paths test done");
    idle(3);
    wrap_up();
  end
endmodule
`default_nettype wire
